// File: design/bus_status_register_defines.vh
`ifndef BUS_STATUS_REGISTER_DEFINES_VH
`define BUS_STATUS_REGISTER_DEFINES_VH

// register byte offsets
`define BUS_STATUS_REGISTER_OFF_OWN_ADDR 12'h000
`define BUS_STATUS_REGISTER_OFF_CONTROL 12'h004
`define BUS_STATUS_REGISTER_OFF_STATUS 12'h008
`define BUS_STATUS_REGISTER_OFF_DATA 12'h00c

// bus_control fields
`define BUS_STATUS_REGISTER_CTL_FLAG 7
`define BUS_STATUS_REGISTER_CTL_ACK_EN 6
`define BUS_STATUS_REGISTER_CTL_START 5
`define BUS_STATUS_REGISTER_CTL_STOP 4
`define BUS_STATUS_REGISTER_CTL_WCOL 3
`define BUS_STATUS_REGISTER_CTL_EN 2
`define BUS_STATUS_REGISTER_CTL_IE 0

// slave_own_address fields
`define BUS_STATUS_REGISTER_OAR_GCE 0
`define BUS_STATUS_REGISTER_GENERAL_CALL 7'h00

// reset values
`define BUS_STATUS_REGISTER_RST_OWN_ADDR 8'h00
`define BUS_STATUS_REGISTER_RST_STATUS 5'h1f
`define BUS_STATUS_REGISTER_RST_DATA 8'hff

// status codes, prescaler bits masked to zero
`define BUS_STATUS_REGISTER_ST_OWN_W 8'h60
`define BUS_STATUS_REGISTER_ST_ARB_OWN_W 8'h68
`define BUS_STATUS_REGISTER_ST_GC 8'h70
`define BUS_STATUS_REGISTER_ST_ARB_GC 8'h78
`define BUS_STATUS_REGISTER_ST_OWN_ACK 8'h80
`define BUS_STATUS_REGISTER_ST_OWN_NACK 8'h88
`define BUS_STATUS_REGISTER_ST_GC_ACK 8'h90
`define BUS_STATUS_REGISTER_ST_GC_NACK 8'h98
`define BUS_STATUS_REGISTER_ST_STOP 8'ha0
`define BUS_STATUS_REGISTER_ST_OWN_R 8'ha8
`define BUS_STATUS_REGISTER_ST_IDLE 8'hf8

`endif

// File: design/bus_status_register_slave_receiver.v
// What this block does
// - match own 7-bit address, general call if enabled
// - acknowledge address only while acknowledge enable set
// - write bit enters receive, read bit sets status a8 and then ignores the bus
// - address plus write sets flag and status
// - lost arbitration then addressed reports 68 or 78
// - acknowledge enable cleared gives nack next byte
// - no address ack while disabled, monitoring continues
// - address match still works in deep sleep
// - sleep match wakes cpu, holds scl until cleared
// - data register may be stale after deep sleep
// - prescaler field masked out of status codes
// - status 60, next byte ack per enable
// - status 68, next byte ack per enable
// - status 70, next byte ack per enable
// - status 78, next byte ack per enable
// - status 80, data byte acknowledged under own address
// - status 88, clear leaves addressed state
// - leaving addressed: recognition per enable, optional start
// - statuses 90 and 98 for general call data
// - status a0 on stop or repeated start
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "bus_status_register_defines.vh"

module bus_status_register_slave_receiver (
  // clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // two-wire bus pins
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // system side
  input wire deep_sleep,
  input wire arb_lost,
  output reg wake_req_q,
  output reg start_pending_q
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_ADDR_ACK = 3'd2;
  localparam [2:0] S_DATA = 3'd3;
  localparam [2:0] S_DATA_ACK = 3'd4;
  localparam [2:0] S_HOLD = 3'd5;
  localparam [2:0] S_IGNORE = 3'd6;

  // status codes in full, and the five bits that the status register keeps
  localparam [7:0] CODE8_OWN_W = `BUS_STATUS_REGISTER_ST_OWN_W;
  localparam [7:0] CODE8_ARB_OWN_W = `BUS_STATUS_REGISTER_ST_ARB_OWN_W;
  localparam [7:0] CODE8_GC = `BUS_STATUS_REGISTER_ST_GC;
  localparam [7:0] CODE8_ARB_GC = `BUS_STATUS_REGISTER_ST_ARB_GC;
  localparam [7:0] CODE8_OWN_ACK = `BUS_STATUS_REGISTER_ST_OWN_ACK;
  localparam [7:0] CODE8_OWN_NACK = `BUS_STATUS_REGISTER_ST_OWN_NACK;
  localparam [7:0] CODE8_GC_ACK = `BUS_STATUS_REGISTER_ST_GC_ACK;
  localparam [7:0] CODE8_GC_NACK = `BUS_STATUS_REGISTER_ST_GC_NACK;
  localparam [7:0] CODE8_STOP = `BUS_STATUS_REGISTER_ST_STOP;
  localparam [7:0] CODE8_OWN_R = `BUS_STATUS_REGISTER_ST_OWN_R;
  localparam [4:0] CODE_OWN_W = CODE8_OWN_W[7:3];
  localparam [4:0] CODE_ARB_OWN_W = CODE8_ARB_OWN_W[7:3];
  localparam [4:0] CODE_GC = CODE8_GC[7:3];
  localparam [4:0] CODE_ARB_GC = CODE8_ARB_GC[7:3];
  localparam [4:0] CODE_OWN_ACK = CODE8_OWN_ACK[7:3];
  localparam [4:0] CODE_OWN_NACK = CODE8_OWN_NACK[7:3];
  localparam [4:0] CODE_GC_ACK = CODE8_GC_ACK[7:3];
  localparam [4:0] CODE_GC_NACK = CODE8_GC_NACK[7:3];
  localparam [4:0] CODE_STOP = CODE8_STOP[7:3];
  localparam [4:0] CODE_OWN_R = CODE8_OWN_R[7:3];

  // pin synchronisers
  reg scl_s1_q;
  reg scl_s2_q;
  reg scl_s3_q;
  reg sda_s1_q;
  reg sda_s2_q;
  reg sda_s3_q;

  // registers
  reg [7:0] own_addr_q;
  reg flag_q;
  reg ack_en_q;
  reg start_req_q;
  reg wcol_q;
  reg en_q;
  reg ie_q;
  reg [4:0] status_q;
  reg [1:0] presc_q;
  reg [7:0] data_q;

  // bus engine
  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg gc_q;
  reg nack_q;
  reg bus_busy_q;
  reg wake_q;

  wire scl_rise = scl_s2_q & ~scl_s3_q;
  wire scl_fall = ~scl_s2_q & scl_s3_q;
  wire start_cond = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  wire stop_cond = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;
  wire addressed = (state_q == S_DATA) || (state_q == S_DATA_ACK) || (state_q == S_HOLD);

  // apb decode
  wire apb_setup = psel & penable & ~pready;
  wire apb_do = psel & penable & pready;
  wire wr_ctl = apb_do & pwrite & (paddr == `BUS_STATUS_REGISTER_OFF_CONTROL);
  wire wr_oar = apb_do & pwrite & (paddr == `BUS_STATUS_REGISTER_OFF_OWN_ADDR);
  wire wr_sts = apb_do & pwrite & (paddr == `BUS_STATUS_REGISTER_OFF_STATUS);
  wire wr_dat = apb_do & pwrite & (paddr == `BUS_STATUS_REGISTER_OFF_DATA);
  wire mapped = (paddr == `BUS_STATUS_REGISTER_OFF_OWN_ADDR) || (paddr == `BUS_STATUS_REGISTER_OFF_CONTROL) ||
                (paddr == `BUS_STATUS_REGISTER_OFF_STATUS) || (paddr == `BUS_STATUS_REGISTER_OFF_DATA);
  wire flag_clr = wr_ctl & pwdata[`BUS_STATUS_REGISTER_CTL_FLAG];

  wire addr_match = (shift_q[7:1] == own_addr_q[7:1]);
  wire gc_match = (shift_q[7:1] == `BUS_STATUS_REGISTER_GENERAL_CALL) & own_addr_q[`BUS_STATUS_REGISTER_OAR_GCE];

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `BUS_STATUS_REGISTER_OFF_OWN_ADDR: rd_mux = {24'h00_0000, own_addr_q};
      `BUS_STATUS_REGISTER_OFF_CONTROL: rd_mux = {24'h00_0000, flag_q, ack_en_q, start_req_q, 1'b0,
                                   wcol_q, en_q, 1'b0, ie_q};
      `BUS_STATUS_REGISTER_OFF_STATUS: rd_mux = {24'h00_0000, status_q, 1'b0, presc_q};
      `BUS_STATUS_REGISTER_OFF_DATA: rd_mux = {24'h00_0000, data_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else if (ce) begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // apb slave: one wait state, unmapped offsets answer with pslverr
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_addr_q <= `BUS_STATUS_REGISTER_RST_OWN_ADDR;
      flag_q <= 1'b0;
      ack_en_q <= 1'b0;
      start_req_q <= 1'b0;
      wcol_q <= 1'b0;
      en_q <= 1'b0;
      ie_q <= 1'b0;
      presc_q <= 2'b00;
      status_q <= `BUS_STATUS_REGISTER_RST_STATUS;
      data_q <= `BUS_STATUS_REGISTER_RST_DATA;
      state_q <= S_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      gc_q <= 1'b0;
      nack_q <= 1'b0;
      bus_busy_q <= 1'b0;
      wake_q <= 1'b0;
      wake_req_q <= 1'b0;
      start_pending_q <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      if (wr_oar) begin
        own_addr_q <= pwdata[7:0];
      end
      if (wr_sts) begin
        presc_q <= pwdata[1:0];
      end
      if (wr_ctl) begin
        ack_en_q <= pwdata[`BUS_STATUS_REGISTER_CTL_ACK_EN];
        start_req_q <= pwdata[`BUS_STATUS_REGISTER_CTL_START];
        en_q <= pwdata[`BUS_STATUS_REGISTER_CTL_EN];
        ie_q <= pwdata[`BUS_STATUS_REGISTER_CTL_IE];
      end
      // data writes are only legal while the flag is up
      if (wr_dat) begin
        if (flag_q) begin
          data_q <= pwdata[7:0];
          wcol_q <= 1'b0;
        end else begin
          wcol_q <= 1'b1;
        end
      end else if (wr_ctl & ~pwdata[`BUS_STATUS_REGISTER_CTL_WCOL]) begin
        wcol_q <= 1'b0;
      end
      if (start_cond) begin
        bus_busy_q <= 1'b1;
      end else if (stop_cond) begin
        bus_busy_q <= 1'b0;
      end
      start_pending_q <= start_req_q & en_q & ~bus_busy_q & ~addressed;
      if (flag_clr) begin
        wake_q <= 1'b0;
      end
      wake_req_q <= wake_q;
      // set wins over a software clear in the same cycle
      if (flag_clr) begin
        flag_q <= 1'b0;
      end
      if (!en_q) begin
        state_q <= S_IDLE;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
      end else if ((start_cond || stop_cond) && state_q != S_HOLD) begin
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
        bit_cnt_q <= 4'h0;
        if (addressed) begin
          flag_q <= 1'b1;
          status_q <= CODE_STOP;
        end
        state_q <= start_cond ? S_ADDR : S_IDLE;
      end else begin
        case (state_q)
          S_IDLE: begin
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
          end
          S_ADDR, S_DATA: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s2_q};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              if (state_q == S_ADDR) begin
                // recognition runs on bus edges alone, also in deep sleep
                if ((addr_match || gc_match) && ack_en_q && !flag_q) begin
                  gc_q <= gc_match & ~addr_match;
                  nack_q <= 1'b0;
                  sda_oe <= 1'b1;
                  state_q <= S_ADDR_ACK;
                  if (deep_sleep) begin
                    wake_q <= 1'b1;
                  end
                end else begin
                  state_q <= S_IGNORE;
                end
              end else begin
                if (!deep_sleep) begin
                  data_q <= shift_q;
                end
                nack_q <= ~ack_en_q;
                sda_oe <= ack_en_q;
                state_q <= S_DATA_ACK;
              end
            end
          end
          S_ADDR_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              if (shift_q[0]) begin
                flag_q <= 1'b1;
                status_q <= CODE_OWN_R;
                state_q <= S_IGNORE;
              end else begin
                flag_q <= 1'b1;
                scl_oe <= 1'b1;
                state_q <= S_HOLD;
                if (gc_q) begin
                  status_q <= arb_lost ? CODE_ARB_GC : CODE_GC;
                end else begin
                  status_q <= arb_lost ? CODE_ARB_OWN_W : CODE_OWN_W;
                end
              end
            end
          end
          S_DATA_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              flag_q <= 1'b1;
              scl_oe <= 1'b1;
              state_q <= S_HOLD;
              if (gc_q) begin
                status_q <= nack_q ? CODE_GC_NACK : CODE_GC_ACK;
              end else begin
                status_q <= nack_q ? CODE_OWN_NACK : CODE_OWN_ACK;
              end
            end
          end
          S_HOLD: begin
            // clock stretched until software clears the flag
            scl_oe <= ~flag_clr;
            if (flag_clr) begin
              state_q <= nack_q ? S_IGNORE : S_DATA;
              bit_cnt_q <= 4'h0;
            end
          end
          S_IGNORE: begin
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
      if (state_q == S_IDLE && status_q == CODE_STOP && flag_clr) begin
        status_q <= `BUS_STATUS_REGISTER_RST_STATUS;
      end
    end
  end

endmodule // bus_status_register_slave_receiver

// File: verif/bus_status_register_master_model.sv
`timescale 1ns/1ps
module bus_status_register_master_model (
  // clock
  input wire pclk,
  // resolved bus levels
  input wire scl,
  input wire sda,
  // open-drain drives, 1 = released
  output logic scl_drv,
  output logic sda_drv
);
  int hang;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // 40 ns step of 8 pclk cycles; scl stays low for two steps and high for one plus the rise wait
  task automatic half();
    repeat (8) @(posedge pclk);
  endtask
  // release scl, then wait while the slave stretches it
  task automatic rise();
    int n;
    scl_drv <= 1'b1;
    do @(posedge pclk); while (scl !== 1'b1 && ++n < 4000);
    if (n == 4000) hang++;
    half();
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    half();
    rise();
    sda_drv <= 1'b0;
    half();
    scl_drv <= 1'b0;
    half();
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    half();
    rise();
    sda_drv <= 1'b1;
    half();
  endtask
  // msb first, ninth clock samples the acknowledge
  task automatic xfer(input logic [7:0] b, output logic s);
    for (int i = 8; i >= 0; i--) begin
      sda_drv <= i ? b[i-1] : 1'b1;
      half();
      rise();
      s = sda;
      scl_drv <= 1'b0;
      half();
    end
  endtask
endmodule // bus_status_register_master_model

// File: verif/bus_status_register_checker.sv
`timescale 1ns/1ps
`include "bus_status_register_defines.vh"
module bus_status_register_checker (
  // clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  // bus and system
  input wire scl_in,
  input wire scl_oe,
  input wire sda_oe,
  input wire deep_sleep,
  input wire wake_req_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire clr = psel && penable && pwrite && pready &&
    paddr == `BUS_STATUS_REGISTER_OFF_CONTROL && pwdata[`BUS_STATUS_REGISTER_CTL_FLAG];
  AST_APB_WAIT: assert property (psel && !penable ##1 ce |-> !pready ##1 pready)
    else $error("apb answer not in second access cycle");
  AST_SLVERR: assert property (pready |-> pslverr == !(paddr inside {0, 4, 8, 12}))
    else $error("slave error flag wrong");
  AST_SCL_HOLD: assert property (scl_oe && !clr && !$past(clr) |=> scl_oe)
    else $error("scl released before flag cleared");
  AST_SCL_FREE: assert property (clr |-> ##2 !scl_oe)
    else $error("scl still held after flag cleared");
  AST_ACK_LOW: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("ack driven while scl high");
  AST_ACK_STEADY: assert property (sda_oe && scl_in |=> sda_oe)
    else $error("ack dropped while scl high");
  AST_WAKE_HOLD: assert property (wake_req_q && !clr && !$past(clr) |=> wake_req_q)
    else $error("wake dropped before flag cleared");
  AST_WAKE_SLEEP: assert property ($rose(wake_req_q) |-> deep_sleep)
    else $error("wake raised outside sleep");
  cover property ($rose(scl_oe));
  cover property ($rose(wake_req_q));
  cover property (pready && pslverr);
endmodule // bus_status_register_checker
bind bus_status_register_slave_receiver bus_status_register_checker bus_status_register_checker_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .scl_in, .scl_oe, .sda_oe, .deep_sleep,
  .wake_req_q, .ce);

// File: verif/bus_status_register_slave_receiver_tb_top.sv
`timescale 1ns/1ps
module bus_status_register_slave_receiver_tb_top;
  logic pclk, presetn, ce, psel, penable, pwrite, deep_sleep, arb_lost, m_scl, m_sda, a, er;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, wake_req_q, start_pending_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [31:0] rst [5] = '{0, 0, 'hf8, 'hff, 0};
  logic [6:0] own;
  logic [7:0] d;
  logic [7:0] q [$];
  int miscompares, comparisons, cycles;
  wire scl = m_scl & (scl_oe ? scl_out : 1'b1);
  wire sda = m_sda & (sda_oe ? sda_out : 1'b1);
  bus_status_register_slave_receiver bus_status_register_slave_receiver_i (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .scl_out, .scl_oe,
    .sda_in(sda), .sda_out, .sda_oe, .deep_sleep, .arb_lost, .wake_req_q, .start_pending_q);
  bus_status_register_master_model bus_status_register_master_model_i (.pclk, .scl, .sda, .scl_drv(m_scl), .sda_drv(m_sda));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] ad, logic [31:0] dt);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 9);
    if (n == 9) begin
      miscompares++;
      report_and_stop();
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // poll the flag, then compare the masked status
  task automatic st(logic [7:0] c);
    int n;
    do apb(0, 'h4, 0); while (rv[7] !== 1'b1 && ++n < 40);
    if (n == 40) begin
      miscompares++;
      report_and_stop();
    end
    apb(0, 'h8, 0);
    chk("status", rv & 32'hfc, {24'h0, c});
  endtask
  task automatic addr(logic [7:0] b);
    bus_status_register_master_model_i.start();
    bus_status_register_master_model_i.xfer(b, a);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // a global cycle limit and a hung partner both end the run as a failure
  always @(posedge pclk) begin
    cycles++;
    if (bus_status_register_master_model_i.hang != 0 || cycles > 90000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    {psel, penable, pwrite, deep_sleep, arb_lost, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    ce = 1'b1;
    void'($urandom(74325));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(0, 12'(4 * i), 0);
      chk("reset", rv, rst[i]);
      chk("slverr", er, i == 4);
    end
    own = 7'($urandom % 127 + 1);
    apb(1, 'h0, {own, 1'b1});
    apb(0, 'h0, 0);
    chk("own", rv, {own, 1'b1});
    apb(1, 'h4, 'h44);
    for (int k = 0; k < 4; k++) begin
      arb_lost <= k[1];
      addr(k[0] ? 8'h00 : {own, 1'b0});
      chk("addr_ack", a, 0);
      st({3'b011, k[0], k[1], 3'b0});
      arb_lost <= 1'b0;
      for (int j = 0; j < 2; j++) begin
        apb(1, 'h4, j ? 'h84 : 'hc4);
        d = 8'($urandom);
        q.push_back(d);
        bus_status_register_master_model_i.xfer(d, a);
        chk("data_ack", a, j);
        st({3'b100, k[0], j[0], 3'b0});
        apb(0, 'hc, 0);
        chk("data", rv, q.pop_front());
      end
      apb(1, 'h4, 'h84);
      addr({own, 1'b0});
      chk("no_recog", a, 1);
      apb(1, 'h4, 'h44);
      bus_status_register_master_model_i.stop();
    end
    apb(1, 'h0, {own, 1'b0});
    addr(8'h00);
    chk("gc_off", a, 1);
    addr({own ^ 7'h1, 1'b0});
    chk("other", a, 1);
    deep_sleep <= 1'b1;
    addr({own, 1'b0});
    chk("sleep_ack", a, 0);
    chk("wake", wake_req_q, 1);
    chk("hold", scl_oe, 1);
    deep_sleep <= 1'b0;
    st(8'h60);
    // with the enable low the slave must not answer the bus request
    ce <= 1'b0;
    fork
      apb(1, 'h4, 'hc4);
      begin
        repeat (3) @(posedge pclk);
        chk("frozen", pready, 0);
        ce <= 1'b1;
      end
    join
    @(posedge pclk);
    chk("wake_clr", wake_req_q, 0);
    bus_status_register_master_model_i.stop();
    st(8'ha0);
    apb(1, 'h4, 'he4);
    @(posedge pclk);
    chk("start_pend", start_pending_q, 1);
    apb(1, 'h4, 'h44);
    addr({own, 1'b1});
    chk("rd_ack", a, 0);
    st(8'ha8);
    chk("hang", bus_status_register_master_model_i.hang, 0);
    report_and_stop();
  end
endmodule // bus_status_register_slave_receiver_tb_top
